// [src/fspc_regs.svh]
`ifndef FSPC_REGS_SVH
`define FSPC_REGS_SVH

// Core clock rate
`define FSPC_CLK_MHZ              40

// Four-byte protection command sequences
`define FSPC_SEQ_BYTE0            8'h3D
`define FSPC_SEQ_BYTE1            8'h2A
`define FSPC_SEQ_BYTE2            8'h7F
`define FSPC_SEQ_ENABLE           8'hA9
`define FSPC_SEQ_DISABLE          8'h9A
`define FSPC_SEQ_BITS             6'h20

// Protection table layout
`define FSPC_SECTORS              16
`define FSPC_SECTOR_PROTECTED     8'hFF
`define FSPC_SECTOR_UNPROTECTED   8'h00
`define FSPC_TABLE_RESET          8'hFF

// Write-protect timing: longest times, rounded down to cycles
`define FSPC_PROTECT_ASSERT_DELAY_NS   1000
`define FSPC_PROTECT_RELEASE_DELAY_NS  1000
`define FSPC_PROTECT_ASSERT_CYCLES  ((`FSPC_PROTECT_ASSERT_DELAY_NS * `FSPC_CLK_MHZ) / 1000)
`define FSPC_PROTECT_RELEASE_CYCLES ((`FSPC_PROTECT_RELEASE_DELAY_NS * `FSPC_CLK_MHZ) / 1000)
// Synchroniser latency taken off the filter span
`define FSPC_SYNC_LATENCY         4
`define FSPC_FILT_ASSERT_COUNT    (`FSPC_PROTECT_ASSERT_CYCLES - `FSPC_SYNC_LATENCY)
`define FSPC_FILT_RELEASE_COUNT   (`FSPC_PROTECT_RELEASE_CYCLES - `FSPC_SYNC_LATENCY)

`endif

// [src/fspc_pkg.sv]
package fspc_pkg;

  typedef struct packed {
    logic sck;
    logic csN;
    logic mosi;
  } fspc_spi_t;

  typedef struct packed {
    logic       valid;
    logic       isTable;
    logic [3:0] sector;
  } fspc_req_t;

  typedef struct packed {
    logic grant;
    logic deny;
  } fspc_ans_t;

  typedef struct packed {
    logic       wrEn;
    logic       eraseEn;
    logic [3:0] wrIdx;
    logic [7:0] wrData;
  } fspc_tbl_wr_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SHIFT,
    SEQ_DEAD
  } fspc_seq_t;

  typedef struct packed {
    logic [2:0] raw;
    logic       level;
    logic [5:0] count;
  } fspc_filt_state_t;

  typedef struct packed {
    logic [2:0]             sckSync;
    logic [2:0]             csSync;
    logic [2:0]             mosiSync;
    logic                   sckLvl;
    logic                   csLvl;
    fspc_seq_t              seq;
    logic [5:0]             bitCnt;
    logic [7:0]             shift;
    logic                   isEnable;
    logic                   swEnable;
    logic [15:0][7:0]       table_;
    fspc_ans_t              ans;
    logic                   enableTaken;
    logic                   disableTaken;
    logic                   seqIgnored;
    logic                   tableWrRefused;
    logic [7:0]             tableRdData;
  } fspc_state_t;

endpackage

// [src/fspc_wp_filter.sv]
`timescale 1ns/1ps
`include "fspc_regs.svh"

module fspc_wp_filter (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic wpN,
  output logic      wpAsserted
);

  localparam logic [5:0] ASSERT_COUNT  = 6'(`FSPC_FILT_ASSERT_COUNT);
  localparam logic [5:0] RELEASE_COUNT = 6'(`FSPC_FILT_RELEASE_COUNT);

  fspc_pkg::fspc_filt_state_t st_reg;
  fspc_pkg::fspc_filt_state_t st_next;
  logic                       agreed;
  logic [5:0]                 limit;

  always_comb
  begin
    st_next = st_reg;
    st_next.raw = {st_reg.raw[1:0], wpN};
    // Stage 2 and 3 agreeing is a stable sample of the pin
    agreed = (st_reg.raw[1] == st_reg.raw[2]);
    // R12: glitch filter
    limit = st_reg.level ? ASSERT_COUNT : RELEASE_COUNT;
    if (agreed && (st_reg.raw[2] != st_reg.level))
    begin
      if (st_reg.count >= limit)
      begin
        st_next.level = st_reg.raw[2];
        st_next.count = 6'h00;
      end
      else
      begin
        st_next.count = st_reg.count + 6'h01;
      end
    end
    else
    begin
      st_next.count = 6'h00;
    end
  end

  // R05: pin idles high, so reset reads as deasserted
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_reg <= '{raw: 3'h7, level: 1'b1, count: 6'h00};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign wpAsserted = ~st_reg.level;

endmodule // fspc_wp_filter

// [src/fspc_ctrl.sv]
// Function
// R01: Sequence 3D 2A 7F A9 sets the software protection enable.
// R02: Sequence 3D 2A 7F 9A clears software enable unless pin forbids.
// R03: Commands act only on chip select rising after exactly 32 bits.
// R04: Reset (power cycle) leaves software protection disabled.
// R05: Floating write-protect pin reads as deasserted (high).
// R06: Pin asserted refuses protected-sector and table program or erase.
// R07: Pin only protects sectors; command effects otherwise unchanged.
// R08: Pin assertion reports protection within the assert delay.
// R09: Pin release drops protection within release delay if no enable.
// R10: Enable before or during pin assertion survives pin release.
// R11: Disable is ignored while the pin is asserted.
// R12: Pin is filtered against short glitches in both directions.
// R13: Status shows protection enabled by software or pin.
// R14: Protection enabled blocks program or erase of flagged sectors.
// R15: Sixteen-byte table, FFh protected, 00h unprotected.
// R16: Erased value FFh marks a sector protected.
// R17: Rejected program or erase starts no internal cycle.
// R18: Mismatched or short sequences leave protection unchanged.
`timescale 1ns/1ps
`include "fspc_regs.svh"

module fspc_ctrl (
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  input  wire fspc_pkg::fspc_spi_t     spiIn,
  input  wire logic                    wpN,
  input  wire fspc_pkg::fspc_req_t     req,
  output fspc_pkg::fspc_ans_t          ans,
  input  wire fspc_pkg::fspc_tbl_wr_t  tableWr,
  input  wire logic [3:0]              tableRdIdx,
  output logic [7:0]                   tableRdData,
  output logic                         protectEnabled,
  output logic                         swEnabled,
  output logic                         hwProtect,
  output logic                         enableTaken,
  output logic                         disableTaken,
  output logic                         seqIgnored,
  output logic                         tableWrRefused
);

  fspc_pkg::fspc_state_t st_reg;
  fspc_pkg::fspc_state_t st_next;
  logic                  wpAsserted;

  // Expected byte for a given position of the sequence
  function automatic logic seqByteOk(input logic [1:0] idx, input logic [7:0] b);
    logic ok;
    ok = 1'b0;
    case (idx)
      2'h0:    ok = (b == `FSPC_SEQ_BYTE0);
      2'h1:    ok = (b == `FSPC_SEQ_BYTE1);
      2'h2:    ok = (b == `FSPC_SEQ_BYTE2);
      2'h3:    ok = (b == `FSPC_SEQ_ENABLE) || (b == `FSPC_SEQ_DISABLE);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // A table byte left erased flags its sector
  function automatic logic sectorFlagged(input logic [7:0] b);
    return b == `FSPC_SECTOR_PROTECTED;
  endfunction

  // Flagged sector under active protection
  function automatic logic sectorLocked(input logic prot, input logic [7:0] b);
    return prot & sectorFlagged(b);
  endfunction

  // Stages 2 and 3 agreeing give a settled pin level
  function automatic logic pinSettled(input logic [2:0] s);
    return s[1] == s[2];
  endfunction

  // Filtered, synchronised write-protect level
  fspc_wp_filter u_wp_filter (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .wpN        (wpN),
    .wpAsserted (wpAsserted)
  );

  logic       sckRise;
  logic       csRise;
  logic       csFall;
  logic [7:0] byteNow;
  logic       protNow;
  logic       lockNow;
  logic       tableLocked;

  always_comb
  begin
    st_next = st_reg;
    st_next.sckSync  = {st_reg.sckSync[1:0], spiIn.sck};
    st_next.csSync   = {st_reg.csSync[1:0], spiIn.csN};
    st_next.mosiSync = {st_reg.mosiSync[1:0], spiIn.mosi};
    sckRise = 1'b0;
    csRise  = 1'b0;
    csFall  = 1'b0;
    // Byte as it stands after the current bit
    byteNow = {st_reg.shift[6:0], st_reg.mosiSync[2]};
    // Answers and outcome strobes last one cycle
    st_next.ans            = '{grant: 1'b0, deny: 1'b0};
    st_next.enableTaken    = 1'b0;
    st_next.disableTaken   = 1'b0;
    st_next.seqIgnored     = 1'b0;
    st_next.tableWrRefused = 1'b0;

    // A pin change counts once stages 2 and 3 agree;
    // stage 1 may still be settling, so it is never decoded
    if (pinSettled(st_reg.sckSync))
    begin
      st_next.sckLvl = st_reg.sckSync[2];
      sckRise = st_reg.sckSync[2] & ~st_reg.sckLvl;
    end
    if (pinSettled(st_reg.csSync))
    begin
      st_next.csLvl = st_reg.csSync[2];
      csRise = st_reg.csSync[2] & ~st_reg.csLvl;
      csFall = ~st_reg.csSync[2] & st_reg.csLvl;
    end

    // Frame decoder: opens on select, judges on deselect
    case (st_reg.seq)
      fspc_pkg::SEQ_IDLE:
      begin
        if (csFall)
        begin
          st_next.seq    = fspc_pkg::SEQ_SHIFT;
          st_next.bitCnt = 6'h00;
          st_next.shift  = 8'h00;
        end
      end
      fspc_pkg::SEQ_SHIFT:
      begin
        // Deselect closes the frame before any late clock edge
        if (csRise)
        begin
          st_next.seq = fspc_pkg::SEQ_IDLE;
          // R03: act only on deselect after the full sequence
          if (st_reg.bitCnt == `FSPC_SEQ_BITS)
          begin
            if (st_reg.isEnable)
            begin
              // R01: enable sets software state
              // R10: survives later pin release
              st_next.swEnable    = 1'b1;
              st_next.enableTaken = 1'b1;
            end
            // R11: disable ignored under the pin
            else if (wpAsserted)
            begin
              st_next.seqIgnored = 1'b1;
            end
            else
            begin
              // R02: disable clears software state
              st_next.swEnable     = 1'b0;
              st_next.disableTaken = 1'b1;
            end
          end
          else
          begin
            // R18: short sequence dropped
            st_next.seqIgnored = 1'b1;
          end
        end
        else if (sckRise)
        begin
          st_next.shift  = byteNow;
          st_next.bitCnt = st_reg.bitCnt + 6'h01;
          // R18: extra bits spoil the command
          if (st_reg.bitCnt == `FSPC_SEQ_BITS)
          begin
            st_next.seq = fspc_pkg::SEQ_DEAD;
          end
          else if (st_reg.bitCnt[2:0] == 3'h7)
          begin
            // R18: any byte mismatch drops the command
            if (!seqByteOk(st_reg.bitCnt[4:3], byteNow))
            begin
              st_next.seq = fspc_pkg::SEQ_DEAD;
            end
            // Only the last byte's value survives to deselect
            st_next.isEnable = (byteNow == `FSPC_SEQ_ENABLE);
          end
        end
      end
      // Spoilt frame: wait for deselect, then report it
      fspc_pkg::SEQ_DEAD:
      begin
        if (csRise)
        begin
          st_next.seq        = fspc_pkg::SEQ_IDLE;
          st_next.seqIgnored = 1'b1;
        end
      end
      default:
      begin
        st_next.seq = fspc_pkg::SEQ_IDLE;
      end
    endcase

    // R13: software or pin enables protection
    // R07: pin adds protection, never changes swEnable
    // R08: pin assertion shows after the filter
    // R09: pin release drops it unless swEnable
    protNow = st_reg.swEnable | wpAsserted;
    lockNow = sectorLocked(protNow, st_reg.table_[req.sector]);
    // Pin alone locks the table; software enable leaves it writable
    tableLocked = wpAsserted;

    // One answer per request, one cycle later
    if (req.valid)
    begin
      if (req.isTable)
      begin
        // R06: table locked while pin asserted
        st_next.ans.deny  = tableLocked;
        st_next.ans.grant = ~tableLocked;
      end
      else
      begin
        // R14: flagged sector blocked when protected
        // R16: erased byte counts as flagged
        // R17: denied request never gets a grant
        st_next.ans.deny  = lockNow;
        st_next.ans.grant = ~lockNow;
      end
    end

    // R06: table writes refused while pin asserted
    if (tableWr.wrEn || tableWr.eraseEn)
    begin
      if (tableLocked)
      begin
        // Refused writes leave the table as it was
        st_next.tableWrRefused = 1'b1;
      end
      else if (tableWr.eraseEn)
      begin
        // R15: erase fills all sixteen bytes
        for (int i = 0; i < `FSPC_SECTORS; i++)
        begin
          st_next.table_[i] = `FSPC_SECTOR_PROTECTED;
        end
      end
      else
      begin
        st_next.table_[tableWr.wrIdx] = tableWr.wrData;
      end
    end

    // Table may always be read
    st_next.tableRdData = st_reg.table_[tableRdIdx];
  end

  // Single state register, asynchronous reset
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // Pin stages reset to idle: deselected, clock low
      st_reg.sckSync        <= 3'h0;
      st_reg.csSync         <= 3'h7;
      st_reg.mosiSync       <= 3'h0;
      st_reg.sckLvl         <= 1'b0;
      st_reg.csLvl          <= 1'b1;
      st_reg.seq            <= fspc_pkg::SEQ_IDLE;
      st_reg.bitCnt         <= 6'h00;
      st_reg.shift          <= 8'h00;
      st_reg.isEnable       <= 1'b0;
      // R04: power-up leaves software protection off
      st_reg.swEnable       <= 1'b0;
      st_reg.table_         <= {`FSPC_SECTORS{`FSPC_TABLE_RESET}};
      st_reg.ans            <= '{grant: 1'b0, deny: 1'b0};
      st_reg.enableTaken    <= 1'b0;
      st_reg.disableTaken   <= 1'b0;
      st_reg.seqIgnored     <= 1'b0;
      st_reg.tableWrRefused <= 1'b0;
      st_reg.tableRdData    <= 8'h00;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Status and strobes straight from registers
  assign ans            = st_reg.ans;
  assign tableRdData    = st_reg.tableRdData;
  assign swEnabled      = st_reg.swEnable;
  assign hwProtect      = wpAsserted;
  assign protectEnabled = st_reg.swEnable | wpAsserted;
  assign enableTaken    = st_reg.enableTaken;
  assign disableTaken   = st_reg.disableTaken;
  assign seqIgnored     = st_reg.seqIgnored;
  assign tableWrRefused = st_reg.tableWrRefused;

endmodule // fspc_ctrl

// [tb/fspc_spi_host.sv]
`timescale 1ns/1ps

module fspc_spi_host (
  input  wire logic           core_clk,
  output fspc_pkg::fspc_spi_t spiIn
);
  // Idle: clock still, deselected, data low
  initial spiIn = 3'h2;

  task automatic send(input logic [31:0] w, input int n);
    @(posedge core_clk);
    #1 spiIn.csN = 1'b0;
    for (int i = 31; i > 31 - n; i--)
    begin
      spiIn.mosi = w[i];
      repeat (5) @(posedge core_clk);
      #1 spiIn.sck = 1'b1;
      repeat (5) @(posedge core_clk);
      #1 spiIn.sck = 1'b0;
    end
    repeat (5) @(posedge core_clk);
    #1 spiIn.csN = 1'b1;
    spiIn.mosi = 1'b0;
  endtask
endmodule // fspc_spi_host

// [tb/fspc_ctrl_properties.sv]
`timescale 1ns/1ps

module fspc_ctrl_properties (
  input wire logic                   core_clk,
  input wire logic                   sys_rst,
  input wire fspc_pkg::fspc_spi_t    spiIn,
  input wire logic                   wpN,
  input wire fspc_pkg::fspc_req_t    req,
  input wire fspc_pkg::fspc_ans_t    ans,
  input wire fspc_pkg::fspc_tbl_wr_t tableWr,
  input wire logic                   protectEnabled,
  input wire logic                   swEnabled,
  input wire logic                   hwProtect,
  input wire logic                   enableTaken,
  input wire logic                   disableTaken,
  input wire logic                   seqIgnored,
  input wire logic                   tableWrRefused
);
  logic       wpPrev;
  logic [6:0] runCnt;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // Cycles since the pin last changed, saturating
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wpPrev <= 1'b1;
      runCnt <= 7'h00;
    end
    else
    begin
      wpPrev <= wpN;
      runCnt <= (wpN != wpPrev) ? 7'h00 : ((runCnt == 7'h7F) ? runCnt : runCnt + 7'h01);
    end
  end

  a_answer_once: assert property (req.valid |=> ans.grant != ans.deny)
    else $error("request answer not exactly one");
  a_no_stray: assert property (!req.valid |=> !ans.grant && !ans.deny)
    else $error("answer without request");
  a_table_lock: assert property (req.valid && req.isTable && hwProtect |=> ans.deny)
    else $error("table change granted under pin");
  a_free_grant: assert property (req.valid && (req.isTable ? !hwProtect : !protectEnabled) |=> ans.grant)
    else $error("unprotected request denied");
  a_status_or: assert property (protectEnabled == (swEnabled || hwProtect))
    else $error("status does not follow sources");
  a_sw_set: assert property ($rose(swEnabled) |-> enableTaken)
    else $error("enable without command");
  a_sw_clear: assert property ($fell(swEnabled) |-> disableTaken && !hwProtect)
    else $error("enable cleared without command");
  a_sw_stable: assert property (!enableTaken && !disableTaken |-> $stable(swEnabled))
    else $error("enable changed without command");
  a_pin_disable: assert property (disableTaken |-> !swEnabled && !hwProtect)
    else $error("disable taken under pin");
  a_cs_release: assert property (enableTaken || disableTaken |-> $past(spiIn.csN, 3))
    else $error("command acted before deselect");
  a_pin_refuse: assert property (tableWr.wrEn && hwProtect |=> tableWrRefused)
    else $error("table write not refused");
  a_glitch_filter: assert property ($changed(hwProtect) |-> $past(wpN, 20) != hwProtect)
    else $error("pin change passed unfiltered");
  a_assert_delay: assert property (runCnt == 7'h2A && !wpPrev |-> hwProtect)
    else $error("pin protection late");
  a_release_delay: assert property (runCnt == 7'h2A && wpPrev |-> !hwProtect)
    else $error("pin release late");

  c_enable: cover property (enableTaken);
  c_disable: cover property (disableTaken);
  c_ignored: cover property (seqIgnored);
  c_deny: cover property (req.valid ##1 ans.deny);
endmodule // fspc_ctrl_properties

bind fspc_ctrl fspc_ctrl_properties i_fspc_ctrl_properties (.*);

// [tb/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
  logic                   core_clk = 1'b0;
  logic                   sys_rst = 1'b1;
  logic                   wpN = 1'b1;
  fspc_pkg::fspc_spi_t    spiIn;
  fspc_pkg::fspc_req_t    req = '0;
  fspc_pkg::fspc_ans_t    ans;
  fspc_pkg::fspc_tbl_wr_t tableWr = '0;
  logic [3:0]             tableRdIdx = 4'h0;
  logic [7:0]             tableRdData;
  logic                   protectEnabled;
  logic                   swEnabled;
  logic                   hwProtect;
  logic                   enableTaken;
  logic                   disableTaken;
  logic                   seqIgnored;
  logic                   tableWrRefused;
  int                     bad_count = 0;
  int                     checks = 0;
  localparam logic [31:0] EN = 32'h3D2A7FA9;
  localparam logic [31:0] DIS = 32'h3D2A7F9A;

  always #12.5 core_clk = ~core_clk;

  fspc_spi_host i_fspc_spi_host (.*);
  fspc_ctrl i_fspc_ctrl (.*);

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t value %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic rst();
    sys_rst = 1'b1;
    cyc(6);
    sys_rst = 1'b0;
  endtask

  // Outcome code: 0 enable, 1 disable, 2 ignored, 3 nothing
  task automatic cmd(input logic [31:0] w, input int n, input logic [1:0] exp);
    logic [1:0] got;
    got = 2'h3;
    i_fspc_spi_host.send(w, n);
    for (int k = 0; k < 20 && got == 2'h3; k++)
    begin
      cyc(1);
      got = enableTaken ? 2'h0 : disableTaken ? 2'h1 : seqIgnored ? 2'h2 : 2'h3;
    end
    chk(got, exp);
    if (got === 2'h3)
      complete_run();
  endtask

  task automatic ask(input logic t, input logic [3:0] s, input logic g);
    req = '{1'b1, t, s};
    cyc(1);
    chk(ans, {g, !g});
    req = '0;
    cyc(1);
  endtask

  task automatic wr(input logic e, input logic [3:0] i, input logic [7:0] d, input logic refused);
    tableWr = '{!e, e, i, d};
    cyc(1);
    chk(tableWrRefused, refused);
    tableWr = '0;
    cyc(1);
  endtask

  task automatic rd(input logic [3:0] i, input logic [7:0] exp);
    tableRdIdx = i;
    cyc(2);
    chk(tableRdData, exp);
  endtask

  task automatic s_reset();
    chk(protectEnabled, 0);
    chk(hwProtect, 0);
    rd(4'h5, 8'hFF);
    ask(0, 4'h5, 1);
    cmd(EN, 32, 0);
    rst();
    chk(swEnabled, 0);
  endtask

  task automatic s_soft();
    cmd(EN, 32, 0);
    chk(swEnabled, 1);
    ask(0, 4'h3, 0);
    wr(0, 4'h3, 8'h00, 0);
    rd(4'h3, 8'h00);
    ask(0, 4'h3, 1);
    ask(1, 4'h0, 1);
    wr(1, 4'h0, 8'h00, 0);
    ask(0, 4'h3, 0);
    cmd(DIS, 32, 1);
    chk(swEnabled, 0);
  endtask

  task automatic s_bad();
    cmd(32'h3D2A7FA8, 32, 2);
    cmd(EN, 24, 2);
    chk(swEnabled, 0);
  endtask

  task automatic s_pin();
    wpN = 1'b0;
    cyc(10);
    wpN = 1'b1;
    cyc(50);
    chk(hwProtect, 0);
    wpN = 1'b0;
    cyc(42);
    chk(protectEnabled, 1);
    wpN = 1'b1;
    cyc(10);
    wpN = 1'b0;
    cyc(50);
    chk(hwProtect, 1);
    ask(1, 4'h2, 0);
    wr(0, 4'h2, 8'h00, 1);
    wr(1, 4'h2, 8'h00, 1);
    rd(4'h2, 8'hFF);
    ask(0, 4'h2, 0);
    cmd(EN, 32, 0);
    cmd(DIS, 32, 2);
    chk(swEnabled, 1);
    wpN = 1'b1;
    cyc(42);
    chk({hwProtect, protectEnabled}, 2'h1);
    cmd(DIS, 32, 1);
    wpN = 1'b0;
    cyc(42);
    wpN = 1'b1;
    cyc(42);
    chk(protectEnabled, 0);
  endtask

  initial
  begin
    rst();
    s_reset();
    s_soft();
    s_bad();
    s_pin();
    complete_run();
  end
endmodule // tb_top
